/* rtl/pll_divider_config_regs.sv */
// Byte-wide configuration register bank feeding the fractional-N synthesizer
`timescale 1ns/10ps
module pll_divider_config_regs
   import synth_cfg_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic second_output_float,
   output logic out1_oe,
   output synth_config_type synth_config
);

   logic ref_predivide_sel;
   logic [3:0] int_div_high;
   logic [7:0] int_div_low;
   logic [5:0] num_top;
   logic [7:0] num_mid;
   logic [7:0] num_bot;
   logic [21:0] num_live;
   logic [5:0] den_top;
   logic [7:0] den_mid;
   logic [7:0] den_bot;
   logic [1:0] dither_sel;
   logic [1:0] order_sel;
   logic doubler_en;
   logic [1:0] ctrl0_spare;
   logic [3:0] pump_sel;
   logic [7:0] next_rdata;

   // One write strobe per register, decoded once so the update processes cannot disagree on the map
   logic ctrl_write;
   logic int_high_write;
   logic int_low_write;
   logic num_top_write;
   logic num_mid_write;
   logic num_bot_write;
   logic den_top_write;
   logic den_mid_write;
   logic den_bot_write;
   logic modulator_write;
   logic synth_ctrl_write;

   // Unmapped offsets raise no strobe, so such writes are ignored
   always_comb begin
      ctrl_write = 1'b0;
      int_high_write = 1'b0;
      int_low_write = 1'b0;
      num_top_write = 1'b0;
      num_mid_write = 1'b0;
      num_bot_write = 1'b0;
      den_top_write = 1'b0;
      den_mid_write = 1'b0;
      den_bot_write = 1'b0;
      modulator_write = 1'b0;
      synth_ctrl_write = 1'b0;
      if (reg_wr) begin
         if (reg_addr == off_refdiv_and_out1_ctrl) begin
            ctrl_write = 1'b1;
         end else if (reg_addr == off_feedback_int_div_high) begin
            int_high_write = 1'b1;
         end else if (reg_addr == off_feedback_int_div_low) begin
            int_low_write = 1'b1;
         end else if (reg_addr == off_frac_numerator_top) begin
            num_top_write = 1'b1;
         end else if (reg_addr == off_frac_numerator_mid) begin
            num_mid_write = 1'b1;
         end else if (reg_addr == off_frac_numerator_bottom) begin
            num_bot_write = 1'b1;
         end else if (reg_addr == off_frac_denominator_top) begin
            den_top_write = 1'b1;
         end else if (reg_addr == off_frac_denominator_mid) begin
            den_mid_write = 1'b1;
         end else if (reg_addr == off_frac_denominator_bottom) begin
            den_bot_write = 1'b1;
         end else if (reg_addr == off_modulator_ctrl) begin
            modulator_write = 1'b1;
         end else if (reg_addr == off_synth_ctrl_doubler_pump) begin
            synth_ctrl_write = 1'b1;
         end
      end
   end

   // Control register at 0x18; bits [7:5] and [3:1] hold nothing
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         second_output_float <= rst_second_output_float;
         ref_predivide_sel <= rst_ref_predivide_sel;
      end else if (ctrl_write) begin
         second_output_float <= reg_wdata[pos_second_output_float];
         ref_predivide_sel <= reg_wdata[pos_ref_predivide_sel];
      end
   end

   // Pin driver turns off one cycle after the float bit is set
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         out1_oe <= 1'b0;
      end else begin
         out1_oe <= ~second_output_float;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         int_div_high <= rst_int_div_high;
         int_div_low <= rst_int_div_low;
      end else begin
         if (int_high_write) begin
            int_div_high <= reg_wdata[3:0];
         end else if (int_low_write) begin
            int_div_low <= reg_wdata;
         end
      end
   end

   // Staged numerator bytes; only the bottom-byte write commits all three
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         num_top <= rst_frac_top;
         num_mid <= rst_frac_byte;
         num_bot <= rst_frac_byte;
         num_live <= {rst_frac_top, rst_frac_byte, rst_frac_byte};
      end else begin
         if (num_top_write) begin
            num_top <= reg_wdata[5:0];
         end else if (num_mid_write) begin
            num_mid <= reg_wdata;
         end else if (num_bot_write) begin
            num_bot <= reg_wdata;
            num_live <= {num_top, num_mid, reg_wdata};
         end
      end
   end

   // Denominator goes live byte by byte; it is set while the loop is idle
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         den_top <= rst_frac_top;
         den_mid <= rst_frac_byte;
         den_bot <= rst_frac_byte;
      end else begin
         if (den_top_write) begin
            den_top <= reg_wdata[5:0];
         end else if (den_mid_write) begin
            den_mid <= reg_wdata;
         end else if (den_bot_write) begin
            den_bot <= reg_wdata;
         end
      end
   end

   // Reserved codes are stored as written; the modulator treats them as unsupported
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         dither_sel <= rst_dither;
         order_sel <= rst_order;
      end else if (modulator_write) begin
         dither_sel <= reg_wdata[pos_dither_lsb +: 2];
         order_sel <= reg_wdata[pos_order_lsb +: 2];
      end
   end

   // A reserved pump code would drive an undefined current, so it is dropped
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         doubler_en <= rst_doubler;
         ctrl0_spare <= rst_ctrl0_spare;
         pump_sel <= rst_pump;
      end else if (synth_ctrl_write) begin
         doubler_en <= reg_wdata[pos_doubler];
         ctrl0_spare <= reg_wdata[pos_ctrl0_spare_lsb +: 2];
         if (reg_wdata[pos_pump_lsb +: 4] == pump_code_low || reg_wdata[pos_pump_lsb +: 4] == pump_code_high) begin
            pump_sel <= reg_wdata[pos_pump_lsb +: 4];
         end
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      if (reg_addr == off_refdiv_and_out1_ctrl) begin
         next_rdata[pos_second_output_float] = second_output_float;
         next_rdata[pos_ref_predivide_sel] = ref_predivide_sel;
      end else if (reg_addr == off_feedback_int_div_high) begin
         next_rdata = {4'h0, int_div_high};
      end else if (reg_addr == off_feedback_int_div_low) begin
         next_rdata = int_div_low;
      end else if (reg_addr == off_frac_numerator_top) begin
         next_rdata = {2'h0, num_top};
      end else if (reg_addr == off_frac_numerator_mid) begin
         next_rdata = num_mid;
      end else if (reg_addr == off_frac_numerator_bottom) begin
         next_rdata = num_bot;
      end else if (reg_addr == off_frac_denominator_top) begin
         next_rdata = {2'h0, den_top};
      end else if (reg_addr == off_frac_denominator_mid) begin
         next_rdata = den_mid;
      end else if (reg_addr == off_frac_denominator_bottom) begin
         next_rdata = den_bot;
      end else if (reg_addr == off_modulator_ctrl) begin
         next_rdata = {4'h0, dither_sel, order_sel};
      end else if (reg_addr == off_synth_ctrl_doubler_pump) begin
         next_rdata = {ctrl0_spare, doubler_en, 1'b0, pump_sel};
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // Synthesizer sees settings one cycle after the register update
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         synth_config <= '{ref_predivide_sel: rst_ref_predivide_sel,
                           feedback_integer_div: {rst_int_div_high, rst_int_div_low},
                           frac_numerator: {rst_frac_top, rst_frac_byte, rst_frac_byte},
                           frac_denominator: {rst_frac_top, rst_frac_byte, rst_frac_byte},
                           modulator_dither_sel: rst_dither,
                           modulator_order: rst_order,
                           doubler_en: rst_doubler,
                           pump_current_sel: rst_pump};
      end else begin
         synth_config.ref_predivide_sel <= ref_predivide_sel;
         synth_config.feedback_integer_div <= {int_div_high, int_div_low};
         synth_config.frac_numerator <= num_live;
         synth_config.frac_denominator <= {den_top, den_mid, den_bot};
         synth_config.modulator_dither_sel <= dither_sel;
         synth_config.modulator_order <= order_sel;
         synth_config.doubler_en <= doubler_en;
         synth_config.pump_current_sel <= pump_sel;
      end
   end

endmodule : pll_divider_config_regs

/* rtl/synth_cfg_pkg.sv */
// Constants and types for the synthesizer configuration register bank
package synth_cfg_pkg;
   localparam logic [7:0] off_refdiv_and_out1_ctrl = 8'h18;
   localparam logic [7:0] off_feedback_int_div_high = 8'h19;
   localparam logic [7:0] off_feedback_int_div_low = 8'h1a;
   localparam logic [7:0] off_frac_numerator_top = 8'h1b;
   localparam logic [7:0] off_frac_numerator_mid = 8'h1c;
   localparam logic [7:0] off_frac_numerator_bottom = 8'h1d;
   localparam logic [7:0] off_frac_denominator_top = 8'h1e;
   localparam logic [7:0] off_frac_denominator_mid = 8'h1f;
   localparam logic [7:0] off_frac_denominator_bottom = 8'h20;
   localparam logic [7:0] off_modulator_ctrl = 8'h21;
   localparam logic [7:0] off_synth_ctrl_doubler_pump = 8'h22;

   localparam int pos_second_output_float = 4;
   localparam int pos_ref_predivide_sel = 0;
   localparam int pos_dither_lsb = 2;
   localparam int pos_order_lsb = 0;
   localparam int pos_doubler = 5;
   localparam int pos_ctrl0_spare_lsb = 6;
   localparam int pos_pump_lsb = 0;

   localparam logic rst_second_output_float = 1'b1;
   localparam logic rst_ref_predivide_sel = 1'b0;
   localparam logic [3:0] rst_int_div_high = 4'h0;
   localparam logic [7:0] rst_int_div_low = 8'h32;
   localparam logic [5:0] rst_frac_top = 6'h00;
   localparam logic [7:0] rst_frac_byte = 8'h00;
   localparam logic [1:0] rst_dither = 2'h3;
   localparam logic [1:0] rst_order = 2'h0;
   localparam logic rst_doubler = 1'b1;
   localparam logic [1:0] rst_ctrl0_spare = 2'h0;
   localparam logic [3:0] rst_pump = 4'h8;

   localparam logic [3:0] pump_code_low = 4'h4;
   localparam logic [3:0] pump_code_high = 4'h8;

   typedef enum logic [1:0] {dither_weak = 2'h0, dither_off = 2'h3} dither_type;
   typedef enum logic [1:0] {order_integer = 2'h0, order_third = 2'h3} order_type;

   typedef struct packed {
      logic ref_predivide_sel;
      logic [11:0] feedback_integer_div;
      logic [21:0] frac_numerator;
      logic [21:0] frac_denominator;
      logic [1:0] modulator_dither_sel;
      logic [1:0] modulator_order;
      logic doubler_en;
      logic [3:0] pump_current_sel;
   } synth_config_type;
endpackage : synth_cfg_pkg

/* testbench/pll_divider_config_regs_sva.sv */
// Port checker for the synthesizer configuration register bank
`timescale 1ns/10ps
module pll_divider_config_regs_sva
   import synth_cfg_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic second_output_float,
   input wire logic out1_oe,
   input wire synth_config_type synth_config
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence wr_at(a);
      reg_wr && reg_addr == a;
   endsequence
   // Upper numerator bytes written with no bottom byte right behind them
   sequence num_staged;
      (wr_at(8'h1b) or wr_at(8'h1c)) ##1 !(reg_wr && reg_addr == 8'h1d);
   endsequence
   float_write_a: assert property (wr_at(8'h18) |=> second_output_float == $past(reg_wdata[4]))
      else $error("float bit not stored");
   oe_follow_a: assert property (1'b1 |=> out1_oe == !$past(second_output_float))
      else $error("output enable wrong");
   predivide_a: assert property (wr_at(8'h18) |=> ##1 synth_config.ref_predivide_sel == $past(reg_wdata[0], 2))
      else $error("predivide select wrong");
   int_high_a: assert property (wr_at(8'h19) |=> ##1 synth_config.feedback_integer_div[11:8] == $past(reg_wdata[3:0], 2))
      else $error("integer divider high wrong");
   num_held_a: assert property (num_staged |=> $stable(synth_config.frac_numerator))
      else $error("numerator moved early");
   num_commit_a: assert property (wr_at(8'h1d) |=> ##1 synth_config.frac_numerator[7:0] == $past(reg_wdata, 2))
      else $error("numerator not committed");
   den_low_a: assert property (wr_at(8'h20) |=> ##1 synth_config.frac_denominator[7:0] == $past(reg_wdata, 2))
      else $error("denominator low wrong");
   pump_legal_a: assert property (synth_config.pump_current_sel inside {4'h4, 4'h8})
      else $error("pump code illegal");
   unmapped_read_a: assert property (reg_rd && (reg_addr < 8'h18 || reg_addr > 8'h22) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule : pll_divider_config_regs_sva

bind pll_divider_config_regs pll_divider_config_regs_sva i_pll_divider_config_regs_sva (.clock, .sys_rst, .reg_addr,
   .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .second_output_float, .out1_oe, .synth_config);

/* testbench/pll_divider_config_regs_test.sv */
// Register bank testbench: reset values, field mapping, commit order
`timescale 1ns/10ps
module pll_divider_config_regs_test;
   import synth_cfg_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
   logic reg_wr, reg_rd, reg_rvalid, second_output_float, out1_oe;
   synth_config_type synth_config;
   synth_config_type e = '{1'b0, 12'h032, 22'h0, 22'h0, 2'h3, 2'h0, 1'b1, 4'h8};
   logic [7:0] rst_vals [11] = '{8'h10, 8'h0, 8'h32, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0c, 8'h28};
   int n_errors = 0;
   int num_checks = 0;
   bit tmo;
   always #4 clock = ~clock;
   reg_host_model i_reg_host_model (.clock, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
   pll_divider_config_regs i_pll_divider_config_regs (.clock, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
      .reg_rdata, .reg_rvalid, .second_output_float, .out1_oe, .synth_config);
   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   task automatic chk8(input logic [7:0] g, input logic [7:0] x);
      num_checks++;
      if (g !== x) begin
         n_errors++;
         $display("Error %0t: byte %h expected %h", $time, g, x);
      end
   endtask : chk8
   task automatic chk_cfg;
      num_checks++;
      if (synth_config !== e) begin
         n_errors++;
         $display("Error %0t: config %h expected %h", $time, synth_config, e);
      end
   endtask : chk_cfg
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      i_reg_host_model.read_reg(a, rv, tmo);
      if (tmo) begin
         n_errors++;
         finish_test();
      end else begin
         chk8(rv, x);
      end
   endtask : rd
   // Two edges after the write is captured: config outputs, then one spare
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_reg_host_model.write_reg(a, d);
      repeat (2) @(posedge clock);
      #1;
   endtask : wr
   initial begin
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      #1;
      chk_cfg();
      chk8({6'h0, out1_oe, second_output_float}, 8'h01);
      for (int k = 0; k < 11; k++) rd(8'h18 + k[7:0], rst_vals[k]);
      wr(8'h18, 8'hef);
      e.ref_predivide_sel = 1'b1;
      chk_cfg();
      chk8({6'h0, out1_oe, second_output_float}, 8'h02);
      rd(8'h18, 8'h01);
      wr(8'h19, 8'hfa);
      wr(8'h1a, 8'h5c);
      e.feedback_integer_div = 12'ha5c;
      chk_cfg();
      rd(8'h19, 8'h0a);
      wr(8'h1b, 8'hff);
      wr(8'h1c, 8'h12);
      chk_cfg();
      rd(8'h1b, 8'h3f);
      rd(8'h1c, 8'h12);
      wr(8'h1d, 8'h34);
      e.frac_numerator = 22'h3f1234;
      chk_cfg();
      wr(8'h1e, 8'hff);
      wr(8'h1f, 8'h56);
      wr(8'h20, 8'h78);
      e.frac_denominator = 22'h3f5678;
      chk_cfg();
      rd(8'h1e, 8'h3f);
      for (int m = 0; m < 4; m++) begin
         wr(8'h21, {4'hf, {2{m[1]}}, {2{m[0]}}});
         e.modulator_dither_sel = {2{m[1]}};
         e.modulator_order = {2{m[0]}};
         chk_cfg();
         rd(8'h21, {4'h0, {2{m[1]}}, {2{m[0]}}});
      end
      wr(8'h22, 8'h04);
      e.doubler_en = 1'b0;
      e.pump_current_sel = 4'h4;
      chk_cfg();
      // Reserved pump code 0x5 must be dropped while the doubler bit still lands
      wr(8'h22, 8'h25);
      e.doubler_en = 1'b1;
      chk_cfg();
      rd(8'h22, 8'h24);
      // Bit 4 is reserved and must read back as zero
      wr(8'h22, 8'hf8);
      e.pump_current_sel = 4'h8;
      rd(8'h22, 8'he8);
      wr(8'h17, 8'hff);
      chk_cfg();
      rd(8'h40, 8'h00);
      finish_test();
   end
endmodule : pll_divider_config_regs_test

/* testbench/reg_host_model.sv */
// Host controller model on the register access port
`timescale 1ns/10ps
module reg_host_model (
   input wire logic clock,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   output logic [7:0] reg_addr = 8'h00,
   output logic reg_wr = 1'b0,
   output logic [7:0] reg_wdata = 8'h00,
   output logic reg_rd = 1'b0
);
   // Released lines show the inverse so stale values cannot pass for good ones
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : write_reg
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output bit tmo);
      tmo = 1'b1;
      d = 8'h00;
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      for (int i = 0; i < 4 && tmo; i++) begin
         @(posedge clock);
         if (reg_rvalid === 1'b1) begin
            d = reg_rdata;
            tmo = 1'b0;
         end
      end
   endtask : read_reg
endmodule : reg_host_model
